//--- hw/plrsd_pkg.sv
package plrsd_pkg;

	// ==================================================
	// Register offsets
	// ==================================================
	localparam logic [7:0] OFF_PLL_CTRL      = 8'h10;
	localparam logic [7:0] OFF_REF_DIV_LOW   = 8'h11;
	localparam logic [7:0] OFF_REF_DIV_HIGH  = 8'h12;
	localparam logic [7:0] OFF_A_COUNT       = 8'h13;
	localparam logic [7:0] OFF_B_COUNT_LOW   = 8'h14;
	localparam logic [7:0] OFF_B_COUNT_HIGH  = 8'h15;
	localparam logic [7:0] OFF_PRESCALER_CFG = 8'h16;
	localparam logic [7:0] OFF_LOCK_OFFSET   = 8'h18;
	localparam logic [7:0] OFF_SYNC_RESET    = 8'h19;
	localparam logic [7:0] OFF_MON_PIN_MUX   = 8'h1b;
	localparam logic [7:0] OFF_REF_SELECT    = 8'h1c;
	localparam logic [7:0] OFF_STATUS_MUX    = 8'h1d;
	localparam logic [7:0] OFF_REF_STATUS    = 8'h1f;

	// ==================================================
	// Reset value and field positions
	// ==================================================
	localparam logic [7:0] REG_RESET_VAL     = 8'h00;
	localparam int         PLL_PD_LSB        = 0;
	localparam int         XTAL_EN_BIT       = 2;
	localparam int         R_RST_BIT         = 6;
	localparam int         SHARED_RST_BIT    = 7;
	localparam int         PRESC_MODE_LSB    = 0;
	localparam int         AB_RST_BIT        = 6;
	localparam int         B_BYPASS_BIT      = 7;
	localparam int         SE_OFFSET_BIT     = 7;
	localparam int         SYNC_EN_LSB       = 6;
	localparam int         DIFF_SEL_BIT      = 0;
	localparam int         SE1_EN_BIT        = 1;
	localparam int         SE2_EN_BIT        = 2;
	localparam int         PREF_SEC_BIT      = 3;
	localparam int         SEL_PIN_BIT       = 4;
	localparam int         AUTO_EN_BIT       = 5;
	localparam int         MAN_SEC_BIT       = 6;
	localparam int         DEGLITCH_DIS_BIT  = 7;
	localparam logic [7:0] MON_MUX_REF_LOSS  = 8'hf7;
	localparam logic [7:0] STAT_MUX_REF_LOSS = 8'h2d;

	// ==================================================
	// Counter widths
	// ==================================================
	localparam int R_W = 14;
	localparam int A_W = 6;
	localparam int B_W = 13;
	localparam int N_W = 19;

	// ==================================================
	// Timing
	// ==================================================
	localparam int CORE_CLK_PERIOD_PS = 25000;
	localparam int REF_LOSS_TIME_NS   = 1000;
	localparam int REF_LOSS_CYCLES    = (REF_LOSS_TIME_NS * 1000) / CORE_CLK_PERIOD_PS;

	// ==================================================
	// Types
	// ==================================================
	typedef enum logic [2:0] {
		PRESC_FD1  = 3'b000,
		PRESC_FD2  = 3'b001,
		PRESC_DM2  = 3'b010,
		PRESC_DM4  = 3'b011,
		PRESC_DM8  = 3'b100,
		PRESC_DM16 = 3'b101,
		PRESC_DM32 = 3'b110,
		PRESC_FD3  = 3'b111
	} plrsd_presc_t;

	typedef enum logic {
		SW_PASS = 1'b0,
		SW_HOLD = 1'b1
	} plrsd_sw_t;

endpackage

//--- hw/plrsd_divider.sv
`timescale 1ns/1ps
module plrsd_divider
	import plrsd_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire logic           clear,
	input  wire logic           tick,
	input  wire logic [N_W-1:0] ratio,
	output logic                pulse_r
);

	logic [N_W-1:0] count_r;
	wire            last_tick;

	// Ratios of zero and one both mean every input edge.
	assign last_tick = (ratio <= N_W'(1)) || (count_r >= ratio - N_W'(1));

	// ==================================================
	// Counter
	// ==================================================
	// automatic reload.
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			count_r <= '0;
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= tick && last_tick;
			if (tick) begin
				count_r <= last_tick ? '0 : count_r + N_W'(1);
			end
		end
	end

endmodule

//--- hw/plrsd_top.sv
`timescale 1ns/1ps
module plrsd_top
	import plrsd_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	output logic      [7:0] reg_rd_data,
	input  wire logic       primary_ref_pin,
	input  wire logic       secondary_ref_pin,
	input  wire logic       fb_clk_pin,
	input  wire logic       ref_sel_pin,
	input  wire logic       sync_n_pin,
	output logic            ref_div_pulse,
	output logic            fb_div_pulse,
	output logic            diff_rx_pd,
	output logic            se_primary_pd,
	output logic            se_secondary_pd,
	output logic            se_offset_en,
	output logic            crystal_amplifier_enable,
	output logic            reference_monitor_pin,
	output logic            status_pin,
	output logic            active_ref_secondary
);

	// ==================================================
	// Functions
	// ==================================================
	// Rising edge of a synchronised level.
	function automatic logic rise(input logic cur, input logic prev);
		rise = cur & ~prev;
	endfunction

	function automatic logic [N_W-1:0] fb_ratio(input logic [2:0] mode,
		input logic [A_W-1:0] a, input logic [B_W-1:0] b, input logic bypass);
		logic [5:0]     p;
		logic           dm;
		logic [N_W-1:0] bb;
		p  = 6'd1;
		dm = 1'b0;
		bb = bypass ? N_W'(1) : N_W'(b);
		case (plrsd_presc_t'(mode))
			PRESC_FD1: p = 6'd1;
			PRESC_FD2: p = 6'd2;
			PRESC_FD3: p = 6'd3;
			PRESC_DM2: begin p = 6'd2; dm = 1'b1; end
			PRESC_DM4: begin p = 6'd4; dm = 1'b1; end
			PRESC_DM8: begin p = 6'd8; dm = 1'b1; end
			PRESC_DM16: begin p = 6'd16; dm = 1'b1; end
			PRESC_DM32: begin p = 6'd32; dm = 1'b1; end
			default: p = 6'd1;
		endcase
		fb_ratio = N_W'(p) * bb + ((dm && !bypass) ? N_W'(a) : N_W'(0));
	endfunction

	// ==================================================
	// Configuration registers
	// ==================================================
	logic [7:0] pll_ctrl_r;
	logic [7:0] rdiv_lo_r;
	logic [7:0] rdiv_hi_r;
	logic [7:0] a_cnt_r;
	logic [7:0] b_lo_r;
	logic [7:0] b_hi_r;
	logic [7:0] presc_r;
	logic [7:0] lock_off_r;
	logic [7:0] sync_ctrl_r;
	logic [7:0] mon_mux_r;
	logic [7:0] ref_sel_r;
	logic [7:0] stat_mux_r;
	logic [7:0] rd_data_r;

	// Write strobes decoded from the address.
	wire wr_pll  = reg_wr_en && (reg_addr == OFF_PLL_CTRL);
	wire wr_rlo  = reg_wr_en && (reg_addr == OFF_REF_DIV_LOW);
	wire wr_rhi  = reg_wr_en && (reg_addr == OFF_REF_DIV_HIGH);
	wire wr_a    = reg_wr_en && (reg_addr == OFF_A_COUNT);
	wire wr_blo  = reg_wr_en && (reg_addr == OFF_B_COUNT_LOW);
	wire wr_bhi  = reg_wr_en && (reg_addr == OFF_B_COUNT_HIGH);
	wire wr_pre  = reg_wr_en && (reg_addr == OFF_PRESCALER_CFG);
	wire wr_lock = reg_wr_en && (reg_addr == OFF_LOCK_OFFSET);
	wire wr_sync = reg_wr_en && (reg_addr == OFF_SYNC_RESET);
	wire wr_mon  = reg_wr_en && (reg_addr == OFF_MON_PIN_MUX);
	wire wr_sel  = reg_wr_en && (reg_addr == OFF_REF_SELECT);
	wire wr_stat = reg_wr_en && (reg_addr == OFF_STATUS_MUX);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pll_ctrl_r  <= REG_RESET_VAL;
			rdiv_lo_r   <= REG_RESET_VAL;
			rdiv_hi_r   <= REG_RESET_VAL;
			a_cnt_r     <= REG_RESET_VAL;
			b_lo_r      <= REG_RESET_VAL;
			b_hi_r      <= REG_RESET_VAL;
			presc_r     <= REG_RESET_VAL;
			lock_off_r  <= REG_RESET_VAL;
			sync_ctrl_r <= REG_RESET_VAL;
			mon_mux_r   <= REG_RESET_VAL;
			ref_sel_r   <= REG_RESET_VAL;
			stat_mux_r  <= REG_RESET_VAL;
		end else begin
			if (wr_pll)  pll_ctrl_r  <= reg_wr_data;
			if (wr_rlo)  rdiv_lo_r   <= reg_wr_data;
			if (wr_rhi)  rdiv_hi_r   <= reg_wr_data;
			if (wr_a)    a_cnt_r     <= reg_wr_data;
			if (wr_blo)  b_lo_r      <= reg_wr_data;
			if (wr_bhi)  b_hi_r      <= reg_wr_data;
			if (wr_pre)  presc_r     <= reg_wr_data;
			if (wr_lock) lock_off_r  <= reg_wr_data;
			if (wr_sync) sync_ctrl_r <= reg_wr_data;
			if (wr_mon)  mon_mux_r   <= reg_wr_data;
			if (wr_sel)  ref_sel_r   <= reg_wr_data;
			if (wr_stat) stat_mux_r  <= reg_wr_data;
		end
	end

	// ==================================================
	// Pin synchronisers
	// ==================================================
	logic [4:0] pin_meta_r;
	logic [4:0] pin_sync_r;
	logic [4:0] pin_prev_r;
	wire  [4:0] pin_raw = {sync_n_pin, ref_sel_pin, fb_clk_pin,
		secondary_ref_pin, primary_ref_pin};

	// Two stages, then one more for edge finding.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_meta_r <= 5'h10;
			pin_sync_r <= 5'h10;
			pin_prev_r <= 5'h10;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	wire pri_rise = rise(pin_sync_r[0], pin_prev_r[0]);
	wire sec_rise = rise(pin_sync_r[1], pin_prev_r[1]);
	wire fb_rise  = rise(pin_sync_r[2], pin_prev_r[2]);
	wire sel_pin  = pin_sync_r[3];
	wire sync_low = ~pin_sync_r[4];

	// ==================================================
	// Reference activity monitors
	// ==================================================
	logic [7:0] idle_cnt_r [2];
	logic [1:0] ref_valid_r;
	wire  [1:0] ref_rise = {sec_rise, pri_rise};

	// A reference is lost when no edge comes within the loss time.
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (srst) begin
				idle_cnt_r[i]  <= 8'(REF_LOSS_CYCLES);
				ref_valid_r[i] <= 1'b0;
			end else begin
				if (ref_rise[i]) begin
					idle_cnt_r[i] <= 8'h00;
				end else if (idle_cnt_r[i] < 8'(REF_LOSS_CYCLES)) begin
					idle_cnt_r[i] <= idle_cnt_r[i] + 8'h01;
				end
				ref_valid_r[i] <= idle_cnt_r[i] < 8'(REF_LOSS_CYCLES);
			end
		end
	end

	// ==================================================
	// Power-down and selection decode
	// ==================================================
	wire pll_pd      = |pll_ctrl_r[PLL_PD_LSB +: 2];
	wire diff_sel    = ref_sel_r[DIFF_SEL_BIT];
	wire pref_sec    = ref_sel_r[PREF_SEC_BIT];
	wire deglitch_on = ~ref_sel_r[DEGLITCH_DIS_BIT];

	wire diff_pd_nxt = ~diff_sel | pll_pd;
	wire se1_pd_nxt  = pll_pd | diff_sel | ~ref_sel_r[SE1_EN_BIT];
	wire se2_pd_nxt  = pll_pd | diff_sel | ~ref_sel_r[SE2_EN_BIT];

	// monitor or status pin may carry the loss flag.
	wire pref_lost   = pref_sec ? ~ref_valid_r[1] : ~ref_valid_r[0];
	wire mon_loss    = (mon_mux_r == MON_MUX_REF_LOSS);
	wire stat_loss   = (stat_mux_r == STAT_MUX_REF_LOSS);
	wire auto_mode   = ref_sel_r[AUTO_EN_BIT] && (mon_loss || stat_loss);

	// manual choice from register or pin.
	wire man_sec     = ref_sel_r[SEL_PIN_BIT] ? sel_pin : ref_sel_r[MAN_SEC_BIT];
	// revertive choice follows the preferred reference.
	wire auto_sec    = pref_sec ^ pref_lost;
	wire sec_nxt     = ~diff_sel & (auto_mode ? auto_sec : man_sec);

	// ==================================================
	// Switchover deglitch
	// ==================================================
	plrsd_sw_t sw_state_r;
	plrsd_sw_t sw_state_nxt;
	logic      active_sec_r;

	wire path_on   = active_sec_r ? ~se_secondary_pd : (diff_sel ? ~diff_rx_pd
		: ~se_primary_pd);
	wire sel_edge  = (active_sec_r ? sec_rise : pri_rise) & path_on;
	wire switching = (sec_nxt != active_sec_r);

	// the held state waits for an edge on the new input.
	// first edge after a switch is swallowed.
	always_comb begin
		case (sw_state_r)
			SW_PASS: sw_state_nxt = (switching && deglitch_on) ? SW_HOLD : SW_PASS;
			SW_HOLD: sw_state_nxt = ((sel_edge && !switching) || !deglitch_on) ? SW_PASS
				: SW_HOLD;
			default: sw_state_nxt = SW_PASS;
		endcase
	end

	wire ref_tick = sel_edge && (sw_state_r == SW_PASS) && !switching;

	// State and active selection.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sw_state_r   <= SW_PASS;
			active_sec_r <= 1'b0;
		end else begin
			sw_state_r   <= sw_state_nxt;
			active_sec_r <= sec_nxt;
		end
	end

	// ==================================================
	// Dividers
	// ==================================================
	// enabled sync pin clears all counters.
	wire sync_hit = (sync_ctrl_r[SYNC_EN_LSB +: 2] != 2'b00) && sync_low;
	wire shared   = rdiv_hi_r[SHARED_RST_BIT];
	wire r_clear  = rdiv_hi_r[R_RST_BIT] | shared | sync_hit;
	wire n_clear  = presc_r[AB_RST_BIT] | shared | sync_hit;

	wire [N_W-1:0] r_ratio = N_W'({rdiv_hi_r[5:0], rdiv_lo_r});
	// nineteen bits hold every feedback ratio.
	wire [N_W-1:0] n_ratio = fb_ratio(presc_r[PRESC_MODE_LSB +: 3], a_cnt_r[A_W-1:0],
		{b_hi_r[4:0], b_lo_r}, presc_r[B_BYPASS_BIT]);

	plrsd_divider u_ref_div (
		.clk     (core_clk),
		.srst    (srst),
		.clear   (r_clear),
		.tick    (ref_tick),
		.ratio   (r_ratio),
		.pulse_r (ref_div_pulse)
	);

	plrsd_divider u_fb_div (
		.clk     (core_clk),
		.srst    (srst),
		.clear   (n_clear),
		.tick    (fb_rise),
		.ratio   (n_ratio),
		.pulse_r (fb_div_pulse)
	);

	// ==================================================
	// Output and read-back registers
	// ==================================================
	logic diff_pd_r;
	logic se1_pd_r;
	logic se2_pd_r;
	logic offset_r;
	logic xtal_r;
	logic mon_pin_r;
	logic stat_pin_r;

	wire [7:0] status_word = {5'h00, active_sec_r, ref_valid_r};
	wire [7:0] rd_mux =
		(reg_addr == OFF_PLL_CTRL)      ? pll_ctrl_r  :
		(reg_addr == OFF_REF_DIV_LOW)   ? rdiv_lo_r   :
		(reg_addr == OFF_REF_DIV_HIGH)  ? rdiv_hi_r   :
		(reg_addr == OFF_A_COUNT)       ? a_cnt_r     :
		(reg_addr == OFF_B_COUNT_LOW)   ? b_lo_r      :
		(reg_addr == OFF_B_COUNT_HIGH)  ? b_hi_r      :
		(reg_addr == OFF_PRESCALER_CFG) ? presc_r     :
		(reg_addr == OFF_LOCK_OFFSET)   ? lock_off_r  :
		(reg_addr == OFF_SYNC_RESET)    ? sync_ctrl_r :
		(reg_addr == OFF_MON_PIN_MUX)   ? mon_mux_r   :
		(reg_addr == OFF_REF_SELECT)    ? ref_sel_r   :
		(reg_addr == OFF_STATUS_MUX)    ? stat_mux_r  :
		(reg_addr == OFF_REF_STATUS)    ? status_word : 8'h00;

	// offset bit drives the bias shift.
	// monitor pin high while preferred input is lost and its mux selects the loss flag.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			diff_pd_r  <= 1'b1;
			se1_pd_r   <= 1'b1;
			se2_pd_r   <= 1'b1;
			offset_r   <= 1'b0;
			xtal_r     <= 1'b0;
			mon_pin_r  <= 1'b0;
			stat_pin_r <= 1'b0;
			rd_data_r  <= 8'h00;
		end else begin
			diff_pd_r  <= diff_pd_nxt;
			se1_pd_r   <= se1_pd_nxt;
			se2_pd_r   <= se2_pd_nxt;
			offset_r   <= lock_off_r[SE_OFFSET_BIT];
			xtal_r     <= pll_ctrl_r[XTAL_EN_BIT] & diff_sel;
			mon_pin_r  <= mon_loss & pref_lost;
			stat_pin_r <= stat_loss & pref_lost;
			rd_data_r  <= rd_mux;
		end
	end

	assign diff_rx_pd               = diff_pd_r;
	assign se_primary_pd            = se1_pd_r;
	assign se_secondary_pd          = se2_pd_r;
	assign se_offset_en             = offset_r;
	assign crystal_amplifier_enable = xtal_r;
	assign reference_monitor_pin    = mon_pin_r;
	assign status_pin               = stat_pin_r;
	assign active_ref_secondary     = active_sec_r;
	assign reg_rd_data              = rd_data_r;

	// ==================================================
	// Assertions
	// ==================================================
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	AST_PATHS_OFF_AFTER_RESET:
	assert property ($past(srst) |-> diff_rx_pd && se_primary_pd && se_secondary_pd)
		else $error("Reference path on right after reset.");

	AST_DIFF_POWER:
	assert property ((!diff_sel || pll_pd) |=> diff_rx_pd)
		else $error("Differential receiver on while not selected.");

	AST_SE_POWER:
	assert property ((pll_pd || diff_sel) |=> se_primary_pd && se_secondary_pd)
		else $error("Single-ended buffer on in differential or pd.");

	AST_OFFSET_FOLLOWS:
	assert property ($rose(lock_off_r[SE_OFFSET_BIT]) |=> se_offset_en)
		else $error("Offset shift not engaged.");

	AST_MONITOR_LOSS:
	assert property (mon_loss && !pref_sec && !ref_valid_r[0] |=> reference_monitor_pin)
		else $error("Monitor pin low while primary lost.");

	AST_DEGLITCH_SWALLOW:
	assert property ($changed(active_sec_r) && $past(deglitch_on) && deglitch_on
		|-> !ref_tick)
		else $error("Edge passed right after a switchover.");

	AST_REVERT_PRIMARY:
	assert property (auto_mode && !pref_sec && ref_valid_r[0] && !diff_sel
		|=> !active_ref_secondary)
		else $error("Automatic mode did not revert to primary.");

	AST_SYNC_CLEARS:
	assert property (sync_hit |=> !ref_div_pulse && !fb_div_pulse)
		else $error("Divider pulsed during sync reset.");

	AST_DIV_BY_ONE:
	assert property (r_ratio <= N_W'(1) && ref_tick && !r_clear |=> ref_div_pulse)
		else $error("Reference ratio zero or one did not divide by one.");

endmodule

//--- test/plrsd_clk_src.sv
`timescale 1ns/1ps
// ==========
// Reference and feedback clock sources
// ==========
module plrsd_clk_src (
	input  wire logic run_primary,
	input  wire logic run_secondary,
	input  wire logic run_fb,
	output logic      primary_ref_pin,
	output logic      secondary_ref_pin,
	output logic      fb_clk_pin
);
	// Each source has a 200 ns period and its own phase, and rests low while stopped.
	// target kept toggling
	initial begin
		primary_ref_pin = 1'b0;
		#13;
		forever #100 primary_ref_pin = run_primary ? ~primary_ref_pin : 1'b0;
	end
	initial begin
		secondary_ref_pin = 1'b0;
		#61;
		forever #100 secondary_ref_pin = run_secondary ? ~secondary_ref_pin : 1'b0;
	end
	initial begin
		fb_clk_pin = 1'b0;
		#37;
		forever #100 fb_clk_pin = run_fb ? ~fb_clk_pin : 1'b0;
	end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import plrsd_pkg::*;
;
	// ==========
	// Stimulus and observed signals
	// ==========
	logic       core_clk = 1'b0;
	logic       srst = 1'b1;
	logic       reg_wr_en = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wr_data = 8'h00;
	logic       ref_sel_pin = 1'b0;
	logic       sync_n_pin = 1'b1;
	logic       run_p = 1'b1;
	logic       run_s = 1'b1;
	logic [7:0] reg_rd_data;
	logic       primary_ref_pin, secondary_ref_pin, fb_clk_pin;
	logic       ref_div_pulse, fb_div_pulse, diff_rx_pd, se_primary_pd, se_secondary_pd;
	logic       se_offset_en, crystal_amplifier_enable, reference_monitor_pin;
	logic       status_pin, active_ref_secondary;
	int         bad_count = 0;
	int         checks = 0;

	// The clock toggles every half period of 12.5 ns.
	always #12.5 core_clk = ~core_clk;

	plrsd_top u_plrsd_top (.core_clk(core_clk), .srst(srst), .reg_wr_en(reg_wr_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.primary_ref_pin(primary_ref_pin), .secondary_ref_pin(secondary_ref_pin),
		.fb_clk_pin(fb_clk_pin), .ref_sel_pin(ref_sel_pin), .sync_n_pin(sync_n_pin),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse), .diff_rx_pd(diff_rx_pd),
		.se_primary_pd(se_primary_pd), .se_secondary_pd(se_secondary_pd),
		.se_offset_en(se_offset_en), .crystal_amplifier_enable(crystal_amplifier_enable),
		.reference_monitor_pin(reference_monitor_pin), .status_pin(status_pin),
		.active_ref_secondary(active_ref_secondary));

	plrsd_clk_src u_plrsd_clk_src (.run_primary(run_p), .run_secondary(run_s),
		.run_fb(1'b1), .primary_ref_pin(primary_ref_pin),
		.secondary_ref_pin(secondary_ref_pin), .fb_clk_pin(fb_clk_pin));

	// ==========
	// Access, measurement and comparison tasks
	// ==========
	task automatic wcyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = d;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		@(negedge core_clk);
		d = reg_rd_data;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkn(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic pulse(input bit fb);
		return fb ? fb_div_pulse : ref_div_pulse;
	endfunction

	// Counts divider pulses in a window after a short settling time.
	task automatic cnt(input bit fb, input int win, output int n);
		n = 0;
		wcyc(10);
		repeat (win) begin
			@(negedge core_clk);
			if (pulse(fb) === 1'b1) n++;
		end
	endtask

	// Measures the cycles between two pulses once the divider has settled.
	task automatic gap(input bit fb, output int n);
		int k;
		k = 0;
		n = 1;
		repeat (2) begin
			k = 0;
			while (pulse(fb) !== 1'b1 && k < 3000) begin
				@(negedge core_clk);
				k++;
			end
			@(negedge core_clk);
		end
		while (pulse(fb) !== 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	function automatic logic [7:0] pds();
		return {4'h0, crystal_amplifier_enable, diff_rx_pd, se_primary_pd, se_secondary_pd};
	endfunction

	function automatic logic [7:0] sel();
		return {5'h00, reference_monitor_pin, status_pin, active_ref_secondary};
	endfunction

	task automatic complete_run;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// The watchdog ends a hung run as a failure.
	initial begin
		#2_000_000;
		bad_count++;
		complete_run();
	end

	// ==========
	// Test sequence
	// ==========
	logic [7:0]   rw_t [6] = '{8'h11, 8'h12, 8'h16, 8'h18, 8'h19, 8'h1b};
	int           r_t [4] = '{0, 1, 5, 300};
	int           rx_t [4] = '{1, 1, 5, 300};
	plrsd_presc_t m_t [10] = '{PRESC_FD1, PRESC_FD2, PRESC_FD3, PRESC_DM2, PRESC_DM4,
		PRESC_DM8, PRESC_DM16, PRESC_DM32, PRESC_FD2, PRESC_DM4};
	logic [7:0]   a_t [10] = '{8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00};
	logic [7:0]   b_t [10] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h01};
	int           n_t [10] = '{3, 6, 9, 7, 14, 24, 51, 97, 2, 4};

	initial begin
		logic [7:0]  v;
		logic [13:0] rv;
		int          n;
		wcyc(10);
		srst = 1'b0;
		chk8(pds(), 8'h07);
		chk8({2'b00, ref_div_pulse, fb_div_pulse, se_offset_en, reference_monitor_pin,
			status_pin, active_ref_secondary}, 8'h00);
		foreach (rw_t[i]) begin
			rd(rw_t[i], v);
			chk8(v, 8'h00);
			wr(rw_t[i], 8'h5a ^ 8'(i));
			rd(rw_t[i], v);
			chk8(v, 8'h5a ^ 8'(i));
			wr(rw_t[i], 8'h00);
		end
		wr(8'h20, 8'hff);
		rd(8'h20, v);
		chk8(v, 8'h00);
		$display("test registers done");

		wr(OFF_REF_SELECT, 8'h01);
		wr(OFF_PLL_CTRL, 8'h04);
		wcyc(3);
		chk8(pds(), 8'h0b);
		wr(OFF_PLL_CTRL, 8'h05);
		wcyc(3);
		chk8(pds()& 8'h07, 8'h07);
		wr(OFF_REF_SELECT, 8'h06);
		wcyc(3);
		chk8(pds(), 8'h07);
		wr(OFF_PLL_CTRL, 8'h00);
		wcyc(3);
		chk8(pds(), 8'h04);
		wr(OFF_REF_SELECT, 8'h02);
		wcyc(3);
		chk8(pds(), 8'h05);
		wr(OFF_LOCK_OFFSET, 8'h80);
		wcyc(3);
		chk8({7'h00, se_offset_en}, 8'h01);
		wr(OFF_LOCK_OFFSET, 8'h00);
		wcyc(3);
		chk8({7'h00, se_offset_en}, 8'h00);
		$display("test power done");

		wr(OFF_REF_SELECT, 8'h46);
		wcyc(60);
		chk8(sel(), 8'h01);
		wr(OFF_REF_SELECT, 8'h16);
		ref_sel_pin = 1'b1;
		wcyc(60);
		chk8(sel(), 8'h01);
		ref_sel_pin = 1'b0;
		wcyc(60);
		chk8(sel(), 8'h00);
		wr(OFF_MON_PIN_MUX, 8'hf7);
		wr(OFF_REF_SELECT, 8'h26);
		wcyc(60);
		chk8(sel(), 8'h00);
		run_p = 1'b0;
		wcyc(120);
		chk8(sel(), 8'h05);
		run_p = 1'b1;
		wcyc(60);
		chk8(sel(), 8'h00);
		wr(OFF_MON_PIN_MUX, 8'h00);
		wr(OFF_STATUS_MUX, 8'h2d);
		run_p = 1'b0;
		wcyc(120);
		chk8(sel(), 8'h03);
		run_p = 1'b1;
		wcyc(60);
		chk8(sel(), 8'h00);
		wr(OFF_REF_SELECT, 8'h2e);
		wcyc(60);
		chk8(sel(), 8'h01);
		run_s = 1'b0;
		wcyc(120);
		chk8(sel(), 8'h02);
		run_s = 1'b1;
		wcyc(60);
		chk8(sel(), 8'h01);
		$display("test switchover done");

		wr(OFF_STATUS_MUX, 8'h00);
		wr(OFF_REF_SELECT, 8'h02);
		foreach (r_t[i]) begin
			rv = 14'(r_t[i]);
			wr(OFF_REF_DIV_LOW, rv[7:0]);
			wr(OFF_REF_DIV_HIGH, {2'b00, rv[13:8]});
			gap(1'b0, n);
			chkn(n, rx_t[i] * 8);
		end
		foreach (m_t[i]) begin
			wr(OFF_A_COUNT, a_t[i]);
			wr(OFF_B_COUNT_LOW, b_t[i]);
			wr(OFF_B_COUNT_HIGH, 8'h00);
			wr(OFF_PRESCALER_CFG, {b_t[i] == 8'h01, 4'h0, m_t[i]});
			gap(1'b1, n);
			chkn(n, n_t[i] * 8);
		end
		$display("test dividers done");

		wr(OFF_REF_DIV_LOW, 8'h01);
		wr(OFF_REF_DIV_HIGH, 8'h40);
		wr(OFF_B_COUNT_LOW, 8'h03);
		wr(OFF_PRESCALER_CFG, 8'h00);
		cnt(1'b0, 240, n);
		chkn(n, 0);
		cnt(1'b1, 240, n);
		chkn(n, 10);
		wr(OFF_REF_DIV_HIGH, 8'h80);
		cnt(1'b0, 240, n);
		chkn(n, 0);
		cnt(1'b1, 240, n);
		chkn(n, 0);
		wr(OFF_REF_DIV_HIGH, 8'h00);
		cnt(1'b0, 240, n);
		chkn(n, 30);
		wr(OFF_PRESCALER_CFG, 8'h40);
		cnt(1'b1, 240, n);
		chkn(n, 0);
		cnt(1'b1, 240, n);
		chkn(n, 0);
		wr(OFF_PRESCALER_CFG, 8'h00);
		cnt(1'b1, 240, n);
		chkn(n, 10);
		sync_n_pin = 1'b0;
		cnt(1'b0, 240, n);
		chkn(n, 30);
		for (int c = 1; c < 4; c++) begin
			wr(OFF_SYNC_RESET, {2'(c), 6'h00});
			cnt(1'b0, 240, n);
			chkn(n, 0);
			cnt(1'b1, 240, n);
			chkn(n, 0);
		end
		sync_n_pin = 1'b1;
		cnt(1'b1, 240, n);
		chkn(n, 10);
		$display("test counter resets done");
		complete_run();
	end
endmodule
